// File: rtl/rib_ctrl.sv
// Purpose: repeat mode, index skip and jump, and buffer channel setup and word service
// Assumes: sequencer issues instr_valid only while busy is low; memory read data valid in the same cycle as mem_rd
// Notes:   index register zero reads as zero and is never written
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/10ps
module rib_ctrl #(
  parameter int NCH = 8
) (
  input  wire logic                  clock,
  input  wire logic                  srst,
  input  wire logic                  instr_valid,
  input  wire logic [5:0]            opcode,
  input  wire logic [2:0]            j_field,
  input  wire logic [1:0]            k_field,
  input  wire logic [29:0]           y_word,
  input  wire logic [14:0]           y_addr,
  output logic                       busy,
  output logic                       instr_done,
  output logic                       skip_next,
  output logic                       jump_take,
  output logic      [14:0]           jump_addr,
  input  wire logic                  rep_start,
  input  wire logic [14:0]           rep_base_addr,
  input  wire logic [2:0]            rep_b_sel,
  input  wire logic                  rep_is_replace,
  input  wire logic                  rep_exec_done,
  input  wire logic                  rep_skip_met,
  output logic                       rep_mode,
  output logic      [14:0]           rep_op_addr,
  output logic      [14:0]           rep_store_addr,
  output logic                       mem_rd,
  output logic                       mem_wr,
  output logic      [14:0]           mem_addr,
  output logic      [29:0]           mem_wdata,
  input  wire logic [29:0]           mem_rdata,
  input  wire logic [NCH-1:0]        in_req,
  input  wire logic [NCH*30-1:0]     in_data,
  output logic      [NCH-1:0]        in_ack,
  input  wire logic [NCH-1:0]        out_req,
  output logic      [NCH-1:0]        out_ack,
  output logic      [29:0]           out_data,
  output logic                       in_mon_int,
  output logic                       out_mon_int,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata
);

  // ------------------------------------------------------------
  // state and working registers
  // ------------------------------------------------------------
  rib_pkg::rib_state_type state_reg;

  logic [14:0] idx_reg [0:7];
  logic [2:0]  desig_reg;
  logic [14:0] rep_base_reg;
  logic [2:0]  rep_bsel_reg;
  logic        rep_repl_reg;
  logic        svc_in_reg;
  logic [2:0]  svc_ch_reg;
  logic [14:0] svc_new_reg;
  logic        svc_last_reg;
  logic [5:0]  cur_op_reg;
  logic [2:0]  cur_j_reg;
  logic [29:0] cur_word_reg;
  logic [14:0] cur_addr_reg;
  logic [1:0]  cur_k_reg;

  logic [NCH-1:0] in_active;
  logic [NCH-1:0] out_active;
  logic           in_sel_valid;
  logic [2:0]     in_sel_ch;
  logic           out_sel_valid;
  logic [2:0]     out_sel_ch;

  logic        accept;
  logic        svc_go;
  logic        is_buf_op;
  logic        is_in_buf;
  logic        is_mon;
  logic [14:0] cw_addr;
  logic [14:0] y_low;
  logic [14:0] sel_idx;
  logic [14:0] cnt_next;
  logic [14:0] rd_low_next;
  logic        rep_end;
  logic [14:0] rep_addr_next;

  logic in_start;
  logic out_start;
  logic in_stop;
  logic out_stop;
  logic in_finish;
  logic out_finish;
  logic in_take;
  logic out_take;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  assign accept    = instr_valid && state_reg == rib_pkg::ST_IDLE;
  assign svc_go    = !instr_valid && state_reg == rib_pkg::ST_IDLE && (in_sel_valid || out_sel_valid);
  assign is_in_buf = opcode == rib_pkg::OP_IBUF || opcode == rib_pkg::OP_IBUF_MON;
  assign is_buf_op = is_in_buf || opcode == rib_pkg::OP_OBUF || opcode == rib_pkg::OP_OBUF_MON;
  assign is_mon    = opcode == rib_pkg::OP_IBUF_MON || opcode == rib_pkg::OP_OBUF_MON;
  assign cw_addr   = (is_in_buf ? rib_pkg::IN_CW_BASE : rib_pkg::OUT_CW_BASE) + 15'(j_field);
  assign y_low     = y_word[14:0];
  assign sel_idx   = idx_reg[j_field];
  assign cnt_next  = idx_reg[rib_pkg::IDX_COUNT] - 15'h0001;
  assign rep_end   = rep_skip_met || cnt_next == rib_pkg::RST_HALF;
  assign rd_low_next = mem_rdata[14:0] + 15'h0001;

  always_comb begin
    case (desig_reg[1:0])
      rib_pkg::RPT_INC:     rep_addr_next = rep_op_addr + 15'h0001;
      rib_pkg::RPT_DEC:     rep_addr_next = rep_op_addr - 15'h0001;
      rib_pkg::RPT_REAPPLY: rep_addr_next = rep_base_reg + idx_reg[rep_bsel_reg];
      default:              rep_addr_next = rep_op_addr;
    endcase
  end

  // ------------------------------------------------------------
  // index registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < 8; i++) begin
        idx_reg[i] <= rib_pkg::RST_HALF;
      end
    end else if (accept && opcode == rib_pkg::OP_REPEAT) begin
      idx_reg[rib_pkg::IDX_COUNT] <= y_low;
    end else if (accept && opcode == rib_pkg::OP_BSKIP && j_field != 3'h0) begin
      if (sel_idx == y_low) begin
        idx_reg[j_field] <= rib_pkg::RST_HALF;
      end else begin
        idx_reg[j_field] <= sel_idx + 15'h0001;
      end
    end else if (accept && opcode == rib_pkg::OP_BJUMP && j_field != 3'h0) begin
      if (sel_idx != rib_pkg::RST_HALF) begin
        idx_reg[j_field] <= sel_idx - 15'h0001;
      end
    end else if (rep_mode && rep_exec_done) begin
      idx_reg[rib_pkg::IDX_COUNT] <= cnt_next;
    end else if (reg_wr && reg_addr[3] == 1'b0 && reg_addr[2:0] != 3'h0) begin
      idx_reg[reg_addr[2:0]] <= reg_wdata[14:0];
    end
  end

  // ------------------------------------------------------------
  // repeat mode
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      rep_mode  <= 1'b0;
      desig_reg <= rib_pkg::RST_DESIG;
    end else if (accept && opcode == rib_pkg::OP_REPEAT) begin
      rep_mode  <= y_low != rib_pkg::RST_HALF;
      desig_reg <= (y_low != rib_pkg::RST_HALF) ? j_field : desig_reg;
    end else if (rep_mode && rep_exec_done && rep_end) begin
      rep_mode <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rep_base_reg   <= rib_pkg::RST_HALF;
      rep_bsel_reg   <= 3'h0;
      rep_repl_reg   <= 1'b0;
      rep_op_addr    <= rib_pkg::RST_HALF;
      rep_store_addr <= rib_pkg::RST_HALF;
    end else if (rep_mode && rep_start) begin
      rep_base_reg   <= rep_base_addr;
      rep_bsel_reg   <= rep_b_sel;
      rep_repl_reg   <= rep_is_replace;
      rep_op_addr    <= rep_base_addr + idx_reg[rep_b_sel];
      rep_store_addr <= rep_base_addr + idx_reg[rep_b_sel]
                        + ((desig_reg[2] && rep_is_replace) ? idx_reg[rib_pkg::IDX_STORE_OFS] : 15'h0000);
    end else if (rep_mode && rep_exec_done) begin
      rep_op_addr    <= rep_addr_next;
      rep_store_addr <= rep_addr_next
                        + ((desig_reg[2] && rep_repl_reg) ? idx_reg[rib_pkg::IDX_STORE_OFS] : 15'h0000);
    end
  end

  // ------------------------------------------------------------
  // sequencer answers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      skip_next <= 1'b0;
      jump_take <= 1'b0;
      jump_addr <= rib_pkg::RST_HALF;
    end else begin
      skip_next <= 1'b0;
      jump_take <= 1'b0;
      if (accept && opcode == rib_pkg::OP_REPEAT) begin
        skip_next <= y_low == rib_pkg::RST_HALF;
      end else if (accept && opcode == rib_pkg::OP_BSKIP) begin
        skip_next <= sel_idx == y_low;
      end else if (accept && opcode == rib_pkg::OP_BJUMP) begin
        jump_take <= sel_idx != rib_pkg::RST_HALF;
        jump_addr <= y_low;
      end else if (rep_mode && rep_exec_done) begin
        skip_next <= rep_skip_met;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      instr_done <= 1'b0;
    end else begin
      instr_done <= (accept && !(is_buf_op && (k_field == rib_pkg::K_ADDR || k_field == rib_pkg::K_LOW15)))
                    || state_reg == rib_pkg::ST_INIT_RD;
    end
  end

  // ------------------------------------------------------------
  // memory sequencing for setup and word service
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg    <= rib_pkg::ST_IDLE;
      busy         <= 1'b0;
      mem_rd       <= 1'b0;
      mem_wr       <= 1'b0;
      mem_addr     <= rib_pkg::RST_HALF;
      mem_wdata    <= '0;
      cur_op_reg   <= 6'h00;
      cur_j_reg    <= 3'h0;
      cur_k_reg    <= 2'h0;
      cur_word_reg <= '0;
      cur_addr_reg <= rib_pkg::RST_HALF;
      svc_in_reg   <= 1'b0;
      svc_ch_reg   <= 3'h0;
      svc_new_reg  <= rib_pkg::RST_HALF;
      svc_last_reg <= 1'b0;
      in_ack       <= '0;
      out_ack      <= '0;
      out_data     <= '0;
    end else begin
      mem_rd  <= 1'b0;
      mem_wr  <= 1'b0;
      in_ack  <= '0;
      out_ack <= '0;
      case (state_reg)
        rib_pkg::ST_IDLE: begin
          busy <= 1'b0;
          if (accept && is_buf_op) begin
            cur_op_reg   <= opcode;
            cur_j_reg    <= j_field;
            cur_k_reg    <= k_field;
            cur_word_reg <= y_word;
            cur_addr_reg <= y_addr;
            mem_addr     <= cw_addr;
            if (k_field == rib_pkg::K_WHOLE) begin
              mem_wr    <= 1'b1;
              mem_wdata <= y_word;
            end else if (k_field != rib_pkg::K_BAD) begin
              mem_rd    <= 1'b1;
              state_reg <= rib_pkg::ST_INIT_RD;
              busy      <= 1'b1;
            end
          end else if (svc_go) begin
            // repeat mode issues no memory writes of its own
            svc_in_reg <= in_sel_valid;
            svc_ch_reg <= in_sel_valid ? in_sel_ch : out_sel_ch;
            mem_rd     <= 1'b1;
            mem_addr   <= (in_sel_valid ? rib_pkg::IN_CW_BASE : rib_pkg::OUT_CW_BASE)
                          + 15'(in_sel_valid ? in_sel_ch : out_sel_ch);
            state_reg  <= rib_pkg::ST_SVC_RD;
            busy       <= 1'b1;
          end
        end
        rib_pkg::ST_INIT_RD: begin
          mem_wr    <= 1'b1;
          mem_wdata <= {mem_rdata[29:15],
                        (cur_k_reg == rib_pkg::K_LOW15) ? cur_word_reg[14:0] : cur_addr_reg};
          state_reg <= rib_pkg::ST_IDLE;
          busy      <= 1'b0;
        end
        rib_pkg::ST_SVC_RD: begin
          if (mem_rdata[29:15] == mem_rdata[14:0]) begin
            state_reg <= rib_pkg::ST_IDLE;
            busy      <= 1'b0;
          end else begin
            mem_wr       <= 1'b1;
            mem_wdata    <= {mem_rdata[29:15], rd_low_next};
            svc_new_reg  <= rd_low_next;
            svc_last_reg <= rd_low_next == mem_rdata[29:15];
            state_reg    <= rib_pkg::ST_SVC_XFER;
          end
        end
        rib_pkg::ST_SVC_XFER: begin
          mem_addr <= svc_new_reg;
          if (svc_in_reg) begin
            mem_wr             <= 1'b1;
            mem_wdata          <= in_data[svc_ch_reg*30 +: 30];
            in_ack[svc_ch_reg] <= 1'b1;
            state_reg          <= rib_pkg::ST_IDLE;
            busy               <= 1'b0;
          end else begin
            mem_rd    <= 1'b1;
            state_reg <= rib_pkg::ST_SVC_OUT;
          end
        end
        rib_pkg::ST_SVC_OUT: begin
          out_data            <= mem_rdata;
          out_ack[svc_ch_reg] <= 1'b1;
          state_reg           <= rib_pkg::ST_IDLE;
          busy                <= 1'b0;
        end
        default: begin
          state_reg <= rib_pkg::ST_IDLE;
          busy      <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // channel flag banks
  // ------------------------------------------------------------
  logic finish_now;
  logic init_now;
  logic init_in;

  assign init_now   = (accept && is_buf_op && k_field == rib_pkg::K_WHOLE) || state_reg == rib_pkg::ST_INIT_RD;
  assign init_in    = (state_reg == rib_pkg::ST_INIT_RD)
                      ? (cur_op_reg == rib_pkg::OP_IBUF || cur_op_reg == rib_pkg::OP_IBUF_MON) : is_in_buf;
  assign finish_now = (state_reg == rib_pkg::ST_SVC_RD && mem_rdata[29:15] == mem_rdata[14:0])
                      || (state_reg == rib_pkg::ST_SVC_XFER && svc_last_reg);
  assign in_start   = init_now && init_in;
  assign out_start  = init_now && !init_in;
  assign in_stop    = accept && opcode == rib_pkg::OP_TERM_IN;
  assign out_stop   = accept && opcode == rib_pkg::OP_TERM_OUT;
  assign in_finish  = finish_now && svc_in_reg;
  assign out_finish = finish_now && !svc_in_reg;
  assign in_take    = svc_go && in_sel_valid;
  assign out_take   = svc_go && !in_sel_valid;

  logic       chan_mon;
  logic [2:0] in_ch;
  logic [2:0] out_ch;

  assign chan_mon = (state_reg == rib_pkg::ST_INIT_RD)
                    ? (cur_op_reg == rib_pkg::OP_IBUF_MON || cur_op_reg == rib_pkg::OP_OBUF_MON) : is_mon;
  assign in_ch  = in_take ? in_sel_ch : (state_reg == rib_pkg::ST_IDLE) ? j_field
                  : (state_reg == rib_pkg::ST_INIT_RD) ? cur_j_reg : svc_ch_reg;
  assign out_ch = out_take ? out_sel_ch : (state_reg == rib_pkg::ST_IDLE) ? j_field
                  : (state_reg == rib_pkg::ST_INIT_RD) ? cur_j_reg : svc_ch_reg;

  rib_chan #(.NCH(NCH)) u_in_chan (
    .clock     (clock),
    .srst      (srst),
    .start     (in_start),
    .mon_in    (chan_mon),
    .stop      (in_stop),
    .finish    (in_finish),
    .ch        (in_ch),
    .take      (in_take),
    .req       (in_req),
    .active    (in_active),
    .mon_fire  (in_mon_int),
    .sel_valid (in_sel_valid),
    .sel_ch    (in_sel_ch)
  );

  rib_chan #(.NCH(NCH)) u_out_chan (
    .clock     (clock),
    .srst      (srst),
    .start     (out_start),
    .mon_in    (chan_mon),
    .stop      (out_stop),
    .finish    (out_finish),
    .ch        (out_ch),
    .take      (out_take),
    .req       (out_req),
    .active    (out_active),
    .mon_fire  (out_mon_int),
    .sel_valid (out_sel_valid),
    .sel_ch    (out_sel_ch)
  );

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (reg_addr[3] == 1'b0) begin
        reg_rdata <= {17'h0_0000, (reg_addr[2:0] == 3'h0) ? 15'h0000 : idx_reg[reg_addr[2:0]]};
      end else if (reg_addr == rib_pkg::REG_STATUS) begin
        reg_rdata <= {12'h000, 8'(out_active), 8'(in_active), desig_reg, rep_mode};
      end else if (reg_addr == rib_pkg::REG_RPT) begin
        reg_rdata <= {2'h0, rep_store_addr, rep_op_addr};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// File: rtl/rib_pkg.sv
// Purpose: constants, types and encodings shared by the repeat, index and buffer control block
// Assumes: 30-bit words, 15-bit halves and addresses, up to eight buffer channels per direction
// Notes:   opcodes are the octal codes 66..76 written in hex
//
// Behaviour
// - repeat loads count register with low 15
// - nonzero count enters repeat, zero skips next
// - repeat runs following instruction count times
// - skip ends repeat and skips next instruction
// - count kept after repeat; memory never altered
// - designator low bits pick operand address step
// - designator bit two offsets replace store address
// - index skip: equal skips and clears register
// - index skip: unequal increments register by one
// - compare low 15 bits; j selects register
// - index jump: nonzero jumps and decrements register
// - index jump: zero continues, register unchanged
// - input control word at octal 100 plus channel
// - output control word at octal 120 plus channel
// - initiation completes; peripheral paces word transfers
// - current address incremented before each transfer
// - buffer ends on restart, terminate or equal halves
// - operand interpretation picks control word write form
// - monitored input buffer interrupts on completion
// - monitored output buffer interrupts on completion
// - termination ends buffer without monitor interrupt
package rib_pkg;

  localparam int WORD_W = 30;
  localparam int HALF_W = 15;
  localparam int CH_W   = 3;

  localparam logic [5:0] OP_TERM_IN  = 6'h36;
  localparam logic [5:0] OP_TERM_OUT = 6'h37;
  localparam logic [5:0] OP_REPEAT   = 6'h38;
  localparam logic [5:0] OP_BSKIP    = 6'h39;
  localparam logic [5:0] OP_BJUMP    = 6'h3a;
  localparam logic [5:0] OP_IBUF     = 6'h3b;
  localparam logic [5:0] OP_OBUF     = 6'h3c;
  localparam logic [5:0] OP_IBUF_MON = 6'h3d;
  localparam logic [5:0] OP_OBUF_MON = 6'h3e;

  localparam logic [14:0] IN_CW_BASE  = 15'h0040;
  localparam logic [14:0] OUT_CW_BASE = 15'h0050;

  localparam logic [1:0] K_ADDR  = 2'h0;
  localparam logic [1:0] K_LOW15 = 2'h1;
  localparam logic [1:0] K_BAD   = 2'h2;
  localparam logic [1:0] K_WHOLE = 2'h3;

  localparam logic [2:0] IDX_COUNT     = 3'h7;
  localparam logic [2:0] IDX_STORE_OFS = 3'h6;

  localparam logic [1:0] RPT_HOLD    = 2'h0;
  localparam logic [1:0] RPT_INC     = 2'h1;
  localparam logic [1:0] RPT_DEC     = 2'h2;
  localparam logic [1:0] RPT_REAPPLY = 2'h3;

  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RPT    = 4'h9;

  localparam logic [14:0] RST_HALF = 15'h0000;
  localparam logic [2:0]  RST_DESIG = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_INIT_RD, ST_SVC_RD, ST_SVC_XFER, ST_SVC_OUT
  } rib_state_type;

endpackage

// File: rtl/rib_chan.sv
// Purpose: per-direction buffer channel flags: active, monitor armed, pending word request
// Assumes: requests are levels from the peripheral, dropped after each acknowledge
// Notes:   lowest pending channel wins service
`timescale 1ns/10ps
module rib_chan #(
  parameter int NCH = 8
) (
  input  wire logic                    clock,
  input  wire logic                    srst,
  input  wire logic                    start,
  input  wire logic                    mon_in,
  input  wire logic                    stop,
  input  wire logic                    finish,
  input  wire logic [rib_pkg::CH_W-1:0] ch,
  input  wire logic                    take,
  input  wire logic [NCH-1:0]          req,
  output logic      [NCH-1:0]          active,
  output logic                         mon_fire,
  output logic                         sel_valid,
  output logic      [rib_pkg::CH_W-1:0] sel_ch
);

  logic [NCH-1:0] mon_reg;
  logic [NCH-1:0] pend_reg;
  logic [NCH-1:0] req_prev_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      active  <= '0;
      mon_reg <= '0;
    end else if (start) begin
      active[ch]  <= 1'b1;
      mon_reg[ch] <= mon_in;
    end else if (stop || finish) begin
      active[ch]  <= 1'b0;
      mon_reg[ch] <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mon_fire <= 1'b0;
    end else begin
      mon_fire <= finish && mon_reg[ch] && !stop;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      req_prev_reg <= '0;
      pend_reg     <= '0;
    end else begin
      req_prev_reg <= req;
      for (int i = 0; i < NCH; i++) begin
        if (req[i] && !req_prev_reg[i] && active[i]) begin
          pend_reg[i] <= 1'b1;
        end else if ((take && ch == rib_pkg::CH_W'(i)) || !active[i]) begin
          pend_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    sel_valid = 1'b0;
    sel_ch    = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        sel_valid = 1'b1;
        sel_ch    = rib_pkg::CH_W'(i);
      end
    end
  end

endmodule

// File: sim/rib_mem.sv
// Purpose: core memory partner for rib_ctrl
// Assumes: read data stand while mem_rd is high
// Notes:   bench reaches m directly
`timescale 1ns/10ps
module rib_mem (
  input  logic        clock,
  input  logic        mem_rd,
  input  logic        mem_wr,
  input  logic [14:0] mem_addr,
  input  logic [29:0] mem_wdata,
  output logic [29:0] mem_rdata
);
  logic [29:0] m [0:32767];
  assign mem_rdata = mem_rd ? m[mem_addr] : ~m[mem_addr];
  always @(posedge clock) if (mem_wr) m[mem_addr] <= mem_wdata;
endmodule

// File: sim/rib_ctrl_props.sv
// Purpose: port checks on rib_ctrl
// Assumes: srst sync, active high
// Notes:   bound below
`timescale 1ns/10ps
module rib_ctrl_props #(
  parameter int NCH = 8
) (
  input logic           clock,
  input logic           srst,
  input logic           instr_valid,
  input logic [5:0]     opcode,
  input logic [1:0]     k_field,
  input logic [29:0]    y_word,
  input logic           busy,
  input logic           instr_done,
  input logic           skip_next,
  input logic           rep_mode,
  input logic           rep_exec_done,
  input logic           rep_skip_met,
  input logic           mem_rd,
  input logic           mem_wr,
  input logic [14:0]    mem_addr,
  input logic [29:0]    mem_wdata,
  input logic [NCH-1:0] in_ack,
  input logic [NCH-1:0] out_ack,
  input logic           in_mon_int
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wire logic take = instr_valid && !busy;
  wire logic isbuf = opcode >= rib_pkg::OP_IBUF && opcode <= rib_pkg::OP_OBUF_MON;
  sequence s_setup;
    ##1 (mem_rd && busy) ##1 (mem_wr && instr_done);
  endsequence
  rpt_zero_a: assert property (take && opcode == rib_pkg::OP_REPEAT && y_word[14:0] == 15'h0000
    |=> skip_next && !rep_mode) else $error("zero no skip");
  rpt_enter_a: assert property (take && opcode == rib_pkg::OP_REPEAT && y_word[14:0] != 15'h0000
    |=> rep_mode && !skip_next) else $error("no repeat");
  rpt_skip_a: assert property (rep_mode && rep_exec_done && rep_skip_met
    |=> !rep_mode && skip_next) else $error("skip end");
  buf_setup_a: assert property (take && isbuf && !k_field[1] |-> s_setup) else $error("setup");
  buf_kbad_a: assert property (take && isbuf && k_field == rib_pkg::K_BAD
    |=> instr_done && !mem_wr) else $error("bad k");
  in_svc_a: assert property (|in_ack |-> mem_wr && mem_addr == $past(mem_wdata[14:0])
    && $past(mem_rd, 2)) else $error("in addr");
  in_cw_a: assert property (|in_ack |-> $past(mem_addr[14:3], 2) == rib_pkg::IN_CW_BASE[14:3])
    else $error("in cw");
  out_cw_a: assert property (|out_ack |-> $past(mem_rd)
    && $past(mem_addr[14:3], 3) == rib_pkg::OUT_CW_BASE[14:3]) else $error("out cw");
  term_quiet_a: assert property (take && opcode == rib_pkg::OP_TERM_IN |=> !in_mon_int [*3])
    else $error("term irq");
endmodule
bind rib_ctrl rib_ctrl_props #(.NCH(NCH)) u_props (.*);

// File: sim/tb.sv
// Purpose: self-checking bench for rib_ctrl
// Assumes: rib_mem as memory, bench as peripheral
// Notes:   seed 92998
`timescale 1ns/10ps
module tb;
  logic          clock, srst, instr_valid, busy, instr_done, skip_next, jump_take, rep_start, rep_is_replace;
  logic          rep_exec_done, rep_skip_met, rep_mode, mem_rd, mem_wr, in_mon_int, out_mon_int, reg_wr, reg_rd;
  logic          sk, jt, ak;
  logic [5:0]    opcode;
  logic [2:0]    j_field, rep_b_sel;
  logic [1:0]    k_field;
  logic [3:0]    reg_addr;
  logic [14:0]   y_addr, jump_addr, rep_base_addr, rep_op_addr, rep_store_addr, mem_addr;
  logic [29:0]   y_word, mem_wdata, mem_rdata, out_data;
  logic [7:0]    in_req, in_ack, out_req, out_ack;
  logic [239:0]  in_data;
  logic [31:0]   reg_wdata, reg_rdata, rd_v, lf;
  int            n_mismatch, num_checks, cyc, mi, mo;
  rib_ctrl dut (.*);
  rib_mem mem (.*);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    mi += in_mon_int;
    mo += out_mon_int;
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(string nm, logic [63:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clock);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge clock);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  task automatic ins(logic [5:0] op, logic [2:0] j, logic [1:0] k, logic [29:0] w);
    @(posedge clock);
    {opcode, j_field, k_field, y_word, y_addr, instr_valid} <= {op, j, k, w, w[14:0], 1'b1};
    @(posedge clock);
    instr_valid <= 1'b0;
    #1 {sk, jt} = {skip_next, jump_take};
    repeat (2) @(posedge clock);
  endtask
  task automatic rp(logic st, logic ex, logic sm);
    @(posedge clock);
    {rep_start, rep_exec_done, rep_skip_met} <= {st, ex, sm};
    @(posedge clock);
    {rep_start, rep_exec_done, rep_skip_met} <= 3'h0;
    #1;
  endtask
  task automatic xf(bit o, int c, logic [29:0] d);
    @(posedge clock);
    in_data[c*30+:30] <= d;
    {out_req[c], in_req[c]} <= {o, !o};
    ak = 1'b0;
    for (int t = 0; t < 20 && !ak; t++) @(posedge clock) #1 ak = o ? out_ack[c] : in_ack[c];
    {in_req, out_req} <= 16'h0000;
    in_data[c*30+:30] <= ~d;
    repeat (3) @(posedge clock);
  endtask
  initial begin
    lf = 32'd92998;
    {srst, instr_valid, rep_start, rep_exec_done, rep_skip_met, reg_wr, reg_rd} = 7'h40;
    {opcode, j_field, k_field, y_word, y_addr, in_req, out_req, in_data, reg_addr, reg_wdata} = '0;
    {rep_base_addr, rep_b_sel, rep_is_replace} = {15'h0100, 3'h1, 1'b1};
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      lf = nx(lf);
      wr(4'(i + i / 8 * 4), lf);
      rd(4'(i + i / 8 * 4));
      chk("index_reg", rd_v, (i % 8 == 0) ? 32'h0 : {17'h0, lf[14:0]});
    end
    wr(3, 32'h0000_1234);
    for (int i = 0; i < 2; i++) begin
      ins(rib_pkg::OP_BSKIP, 3, 0, {lf[14:0], 15'h1234 >> (i * 12)});
      rd(3);
      chk("bskip", {sk, rd_v[30:0]}, {i == 0, 31'(i)});
    end
    wr(2, 32'h0000_0001);
    for (int i = 1; i >= 0; i--) begin
      ins(rib_pkg::OP_BJUMP, 2, 0, {lf[29:15], 15'h0321});
      rd(2);
      chk("bjump", {jt, jump_addr, rd_v[15:0]}, {i == 1, 15'h0321, 16'h0});
    end
    ins(rib_pkg::OP_REPEAT, 1, 0, 30'h0000_8000);
    chk("rpt_zero", sk, 1);
    wr(6, 32'h0000_0010);
    wr(1, 32'h0000_0004);
    ins(rib_pkg::OP_REPEAT, 5, 0, 30'h0000_0003);
    rd(7);
    chk("rpt_count", rd_v, 3);
    rp(1, 0, 0);
    chk("rpt_addr", {rep_store_addr, rep_op_addr}, {15'h0114, 15'h0104});
    for (int i = 2; i >= 0; i--) begin
      rp(0, 1, 0);
      chk("rpt_step", {rep_mode, rep_op_addr}, {i != 0, 15'h0107 - 15'(i)});
    end
    ins(rib_pkg::OP_REPEAT, 2, 0, 30'h0000_0004);
    rp(1, 0, 0);
    rp(0, 1, 1);
    rd(7);
    chk("rpt_skip", {rep_mode, rd_v}, {1'b0, 32'h3});
    ins(rib_pkg::OP_IBUF_MON, 2, 3, {15'h0202, 15'h0200});
    for (int i = 1; i < 3; i++) begin
      lf = nx(lf);
      xf(0, 2, lf[29:0]);
      chk("in_word", mem.m[15'h0200 + 15'(i)], lf[29:0]);
    end
    chk("in_done", {mi, mem.m[15'h0042]}, {2'h1, 15'h0202, 15'h0202});
    mem.m[15'h0051] = {15'h0302, 15'h0};
    mem.m[15'h0301] = 30'h1555_5555;
    mem.m[15'h0302] = 30'h2aaa_aaaa;
    ins(rib_pkg::OP_OBUF_MON, 1, 1, 30'h0300);
    for (int i = 1; i < 3; i++) begin
      xf(1, 1, 30'h0);
      chk("out_word", out_data, mem.m[15'h0300 + 15'(i)]);
    end
    rd(8);
    chk("out_done", {mo, rd_v[19:4]}, {2'h1, 16'h0});
    mem.m[15'h0054] = 30'h0;
    mem.m[15'h0043] = {15'h0012, 15'h0};
    ins(rib_pkg::OP_OBUF, 4, 2, 30'h7fff);
    ins(rib_pkg::OP_IBUF, 3, 0, 30'h0010);
    rd(8);
    chk("setup", {mem.m[15'h0054], mem.m[15'h0043], rd_v[7]}, {30'h0, 15'h0012, 15'h0010, 1'b1});
    ins(rib_pkg::OP_TERM_IN, 3, 0, 30'h0);
    xf(0, 3, 30'h1);
    chk("term", {ak, mi}, {1'b0, 2'h1});
    ins(rib_pkg::OP_TERM_OUT, 1, 0, 30'h0);
    report_and_stop();
  end
endmodule
